// ---- cwt_pkg.sv ----
// Package for the selective-wake bit-timing and wake-frame identifier registers.
// Assumes a 7-bit register address and 16-bit register data from the serial interface.
package cwt_pkg;

    // Register addresses
    localparam logic [6:0]  CWT_ADDR_BIT_TIMING = 7'h31;
    localparam logic [6:0]  CWT_ADDR_ID_HIGH    = 7'h32;
    localparam logic [6:0]  CWT_ADDR_ID_LOW     = 7'h33;

    // Reset values for power-on and soft reset
    localparam logic [15:0] CWT_RST_BIT_TIMING  = 16'hcc96;
    localparam logic [15:0] CWT_RST_ID_HIGH     = 16'h0000;
    localparam logic [15:0] CWT_RST_ID_LOW      = 16'h0000;

    // Bit-timing field layout
    localparam int          CWT_SP_MSB          = 15;
    localparam int          CWT_SP_LSB          = 10;
    localparam int          CWT_QPB_MSB         = 7;
    localparam int          CWT_QPB_LSB         = 0;
    // Writable bits of the bit-timing register; 9:8 read as zero
    localparam logic [15:0] CWT_BIT_TIMING_WMASK = 16'hfcff;

    // Low identifier field layout
    localparam int          CWT_IDL_HI_MSB      = 15;
    localparam int          CWT_IDL_HI_LSB      = 8;
    localparam int          CWT_IDL_LO_MSB      = 6;
    localparam int          CWT_IDL_LO_LSB      = 2;
    localparam int          CWT_IDL_RTR_BIT     = 1;
    localparam int          CWT_IDL_IDE_BIT     = 0;
    // Writable bits of the low identifier register; bit 7 reads as zero
    localparam logic [15:0] CWT_ID_LOW_WMASK    = 16'hff7f;

    // Identifier widths; a standard identifier occupies the top 11 bits
    localparam int          CWT_ID_WIDTH        = 29;
    localparam int          CWT_STD_ID_WIDTH    = 11;
    localparam logic [28:0] CWT_STD_ID_SEL      = 29'h1ffc0000;
    localparam logic [28:0] CWT_EXT_ID_SEL      = 29'h1fffffff;

    // Whole state of the register bank
    typedef struct packed {
        logic [15:0] bit_timing;
        logic [15:0] id_high;
        logic [15:0] id_low;
        logic        config_valid;
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        wake_up_frame;
        logic [1:0]  tq_prescaler;
    } cwt_state_type;

endpackage

// ---- cwt_regs.sv ----
// Selective-wake bit-timing and wake-frame identifier registers with frame matcher.
// Assumes the serial interface decoder on the same clock presents single-cycle
// write and read strobes; received frame fields come from a decoder on this clock.
`timescale 1ns/1ps

module cwt_regs (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          soft_reset,
    input  wire logic                          restart,
    input  wire logic                          wr_en,
    input  wire logic [6:0]                    wr_addr,
    input  wire logic [15:0]                   wr_data,
    input  wire logic                          rd_en,
    input  wire logic [6:0]                    rd_addr,
    output logic [15:0]                        rd_data,
    output logic                               rd_valid,
    input  wire logic                          other_config_write,
    input  wire logic                          config_valid_set,
    input  wire logic                          config_valid_clear,
    output logic                               config_valid_flag,
    input  wire logic [1:0]                    tq_prescaler_in,
    output logic [1:0]                         tq_prescaler,
    output logic [5:0]                         sample_point_fraction,
    output logic [7:0]                         quanta_per_bit,
    input  wire logic                          selective_wake_function,
    output logic                               selective_wake_active,
    input  wire logic [cwt_pkg::CWT_ID_WIDTH-1:0] id_compare_mask_bit,
    input  wire logic                          rx_frame_valid,
    input  wire logic [cwt_pkg::CWT_ID_WIDTH-1:0] rx_frame_id,
    input  wire logic                          rx_frame_ide,
    input  wire logic                          rx_frame_rtr,
    output logic                               wake_up_frame,
    output logic [cwt_pkg::CWT_ID_WIDTH-1:0]   wake_frame_id_bit,
    output logic                               wake_frame_rtr,
    output logic                               wake_frame_ide
);
    import cwt_pkg::*;

    // Whole bank state lives in one packed struct.
    // The register copy and its next value are the only storage;
    // every output below is either a slice of it or a plain
    // combination of it with same-clock inputs.
    // Keeping it in one place makes the reset and restart
    // behaviour easy to audit field by field.
    cwt_state_type state_reg;
    cwt_state_type state_next;

    // Frame compare helpers.
    // id_sel picks the identifier bits that take part in the
    // compare: the software mask, narrowed to the top bits for
    // a standard identifier.
    // id_diff holds the compared bits that disagree.
    // cfg_write marks a write to any register of this bank.

    logic [CWT_ID_WIDTH-1:0] id_sel;
    logic [CWT_ID_WIDTH-1:0] id_diff;
    logic                    frame_match;
    logic                    cfg_write;

    // Stored identifier reassembled from both registers.
    // The high register carries the top sixteen identifier bits;
    // the low register carries the remaining thirteen split
    // around the reserved bit, then the frame type and format.
    // The reserved bit is skipped so the identifier is contiguous
    // for the compare logic.
    assign wake_frame_id_bit = {state_reg.id_high,
                                state_reg.id_low[CWT_IDL_HI_MSB:CWT_IDL_HI_LSB],
                                state_reg.id_low[CWT_IDL_LO_MSB:CWT_IDL_LO_LSB]};
    assign wake_frame_rtr    = state_reg.id_low[CWT_IDL_RTR_BIT];
    assign wake_frame_ide    = state_reg.id_low[CWT_IDL_IDE_BIT];

    // Timing fields taken straight from the register.
    // The sample point is an unsigned fraction below one, top bit
    // worth one half; the bit-time count is a plain quanta count.
    // Neither is checked for sense here: a zero count is stored
    // and presented as written, the bit sampler must cope.
    // The quantum length itself comes from the prescaler field,
    // which lives in another register and is only copied here.
    assign sample_point_fraction = state_reg.bit_timing[CWT_SP_MSB:CWT_SP_LSB];
    assign quanta_per_bit        = state_reg.bit_timing[CWT_QPB_MSB:CWT_QPB_LSB];
    assign tq_prescaler          = state_reg.tq_prescaler;

    // Registered outputs, plus the unregistered wake enable.
    // The wake enable is a gate of the stored flag and the outside
    // enable; it drops in the same cycle as either of them.
    assign config_valid_flag     = state_reg.config_valid;
    assign rd_data               = state_reg.rd_data;
    assign rd_valid              = state_reg.rd_valid;
    assign wake_up_frame         = state_reg.wake_up_frame;
    assign selective_wake_active = state_reg.config_valid & selective_wake_function;

    // Mask selects compared bits; a standard frame has only the top 11 bits.
    // The stored format bit decides the width of the compare, so a
    // standard setup ignores the lower identifier bits even when
    // the mask has them set.
    // Format and frame type are always compared, never masked.
    always_comb begin
        id_sel      = id_compare_mask_bit & (wake_frame_ide ? CWT_EXT_ID_SEL : CWT_STD_ID_SEL);
        id_diff     = (rx_frame_id ^ wake_frame_id_bit) & id_sel;
        frame_match = rx_frame_valid && selective_wake_active
                      && (id_diff == '0)
                      && (rx_frame_ide == wake_frame_ide)
                      && (rx_frame_rtr == wake_frame_rtr);
    end

    // Any write to this bank counts as a configuration change.
    // Rewriting the same value still clears the valid flag; the
    // software must validate again after every change.
    assign cfg_write = wr_en && ((wr_addr == CWT_ADDR_BIT_TIMING) ||
                                 (wr_addr == CWT_ADDR_ID_HIGH) ||
                                 (wr_addr == CWT_ADDR_ID_LOW));

    // Next-state logic for the whole bank.
    // Priority, lowest first: hold, write, flag update, read,
    // restart, soft reset. Soft reset is last so it beats the others on every field it loads.
    // Read data is taken from the current register, so a read and
    // a write to one address in one cycle return the old value.
    always_comb begin
        state_next               = state_reg;
        state_next.rd_valid      = 1'b0;
        state_next.wake_up_frame = frame_match;
        state_next.tq_prescaler  = tq_prescaler_in;

        // Register writes; reserved bits are masked so they never store a one
        if (wr_en) begin
            case (wr_addr)
                CWT_ADDR_BIT_TIMING: begin
                    state_next.bit_timing = wr_data & CWT_BIT_TIMING_WMASK;
                end
                CWT_ADDR_ID_HIGH: begin
                    state_next.id_high = wr_data;
                end
                CWT_ADDR_ID_LOW: begin
                    state_next.id_low = wr_data & CWT_ID_LOW_WMASK;
                end
                default: begin
                    state_next.id_low = state_reg.id_low;
                end
            endcase
        end

        // Hardware clears on wake or config change; a software set in the same cycle wins.
        // Letting the set win keeps a validate strobe from being lost
        // behind an unrelated clear; the software sees the flag high.
        if (frame_match || cfg_write || other_config_write || config_valid_clear) begin
            state_next.config_valid = 1'b0;
        end
        if (config_valid_set) begin
            state_next.config_valid = 1'b1;
        end

        // Reads return one cycle later; unmapped addresses read zero
        if (rd_en) begin
            state_next.rd_valid = 1'b1;
            case (rd_addr)
                CWT_ADDR_BIT_TIMING: state_next.rd_data = state_reg.bit_timing & CWT_BIT_TIMING_WMASK;
                CWT_ADDR_ID_HIGH:    state_next.rd_data = state_reg.id_high;
                CWT_ADDR_ID_LOW:     state_next.rd_data = state_reg.id_low & CWT_ID_LOW_WMASK;
                default:             state_next.rd_data = '0;
            endcase
        end

        // Restart keeps the writable fields; only reserved bits are forced low.
        // Reserved bits never hold a one anyway; the masking here
        // guards against a corrupted bank after a brown-out.
        if (restart) begin
            state_next.bit_timing = state_reg.bit_timing & CWT_BIT_TIMING_WMASK;
            state_next.id_high    = state_reg.id_high;
            state_next.id_low     = state_reg.id_low & CWT_ID_LOW_WMASK;
        end

        // Soft reset loads the power-on register values, clears flag and wake pulse; a read in the same cycle still answers
        if (soft_reset) begin
            state_next.bit_timing    = CWT_RST_BIT_TIMING;
            state_next.id_high       = CWT_RST_ID_HIGH;
            state_next.id_low        = CWT_RST_ID_LOW;
            state_next.config_valid  = 1'b0;
            state_next.wake_up_frame = 1'b0;
        end
    end

    // State register; power-on reset loads documented defaults.
    // Only constants appear in the reset branch; read data, read
    // valid, wake pulse and prescaler copy start at zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg               <= '0;
            state_reg.bit_timing    <= CWT_RST_BIT_TIMING;
            state_reg.id_high       <= CWT_RST_ID_HIGH;
            state_reg.id_low        <= CWT_RST_ID_LOW;
            state_reg.config_valid  <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

// ---- cwt_regs_properties.sv ----
// Assertions on the wake timing and identifier register ports.
// Assumes a bind onto cwt_regs; one clock, reset rst.
`timescale 1ns/1ps
module cwt_regs_properties (
    input wire logic        clk, rst, soft_reset, restart, wr_en, rd_valid, config_valid_set,
    input wire logic        config_valid_flag, rx_frame_valid, selective_wake_active, selective_wake_function,
    input wire logic        wake_up_frame, wake_frame_rtr, wake_frame_ide,
    input wire logic [6:0]  wr_addr, rd_addr,
    input wire logic [15:0] wr_data, rd_data,
    input wire logic [1:0]  tq_prescaler_in, tq_prescaler,
    input wire logic [5:0]  sample_point_fraction,
    input wire logic [7:0]  quanta_per_bit,
    input wire logic [28:0] wake_frame_id_bit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Field writes show one cycle later; soft reset wins
    a_timing_write: assert property (
        wr_en && wr_addr == 7'h31 && !soft_reset |=> sample_point_fraction == $past(wr_data[15:10])
        && quanta_per_bit == $past(wr_data[7:0])) else $error("timing fields not written");
    a_high_write: assert property (
        wr_en && wr_addr == 7'h32 && !soft_reset |=> wake_frame_id_bit[28:13] == $past(wr_data))
        else $error("high id not written");
    a_low_write: assert property (
        wr_en && wr_addr == 7'h33 && !soft_reset |=> wake_frame_id_bit[12:0] == {$past(wr_data[15:8]),
        $past(wr_data[6:2])} && {wake_frame_rtr, wake_frame_ide} == $past(wr_data[1:0])) else $error("low id bad");
    // Reserved bits never read back as one
    a_res_read: assert property (
        rd_valid |-> !($past(rd_addr) == 7'h31 && rd_data[9:8] != 2'h0) && !($past(rd_addr) == 7'h33 && rd_data[7]))
        else $error("reserved bit read as one");
    a_prescale_copy: assert property (
        !soft_reset |=> tq_prescaler == $past(tq_prescaler_in)) else $error("prescaler not followed");
    a_soft_default: assert property (
        soft_reset |=> {sample_point_fraction, quanta_per_bit} == 14'h3396 && wake_frame_id_bit == 29'h0
        && !config_valid_flag) else $error("soft reset defaults wrong");
    a_restart_keep: assert property (
        restart && !wr_en && !soft_reset |=> $stable(sample_point_fraction) && $stable(quanta_per_bit)
        && $stable(wake_frame_id_bit) && $stable(wake_frame_rtr) && $stable(wake_frame_ide)) else $error("restart lost");
    a_flag_clear: assert property (
        wr_en && wr_addr inside {[7'h31:7'h33]} && !config_valid_set |=> !config_valid_flag)
        else $error("flag kept after write");
    a_wake_cause: assert property (
        wake_up_frame |-> $past(rx_frame_valid && selective_wake_active)) else $error("wake without cause");
    a_active_gate: assert property (
        selective_wake_active == (config_valid_flag && selective_wake_function)) else $error("active gate wrong");
endmodule

// ---- cwt_mcu_model.sv ----
// Microcontroller model: register writes, reads and flag set.
// Assumes one clock; strobes last one cycle, lines inverted when idle.
`timescale 1ns/1ps
module cwt_mcu_model (
    input  wire logic        clk,
    output logic             wr_en, rd_en, config_valid_set,
    output logic [6:0]       wr_addr, rd_addr,
    output logic [15:0]      wr_data
);
    initial {wr_en, rd_en, config_valid_set, wr_addr, rd_addr, wr_data} = '0;
    // Idle lines inverted so stale data is never trusted
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk) {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
        @(posedge clk) {wr_en, wr_addr, wr_data} <= {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [6:0] a);
        @(posedge clk) {rd_en, rd_addr} <= {1'b1, a};
        @(posedge clk) {rd_en, rd_addr} <= {1'b0, ~a};
    endtask
    // Called only once the configuration is written
    task automatic validate();
        @(posedge clk) config_valid_set <= 1'b1;
        @(posedge clk) config_valid_set <= 1'b0;
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the wake timing and identifier registers.
// Assumes cwt_regs, cwt_mcu_model and the checker are compiled first.
`timescale 1ns/1ps
module tb;
    import cwt_pkg::*;
    logic        clk = 0, rst = 1, soft_reset = 0, restart = 0, selective_wake_function = 1;
    logic        rx_frame_valid = 0, rx_frame_ide = 0, rx_frame_rtr = 0, fr_d = 0;
    logic        other_config_write = 0, config_valid_clear = 0, rd_valid, wake_up_frame;
    logic        wr_en, rd_en, config_valid_set, config_valid_flag, selective_wake_active;
    logic        wake_frame_rtr, wake_frame_ide;
    logic [1:0]  tq_prescaler_in = 0, tq_prescaler;
    logic [5:0]  sample_point_fraction;
    logic [7:0]  quanta_per_bit;
    logic [6:0]  wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, bt, hi, lo, rq[$];
    logic [28:0] id_compare_mask_bit = '1, rx_frame_id = 0, wake_frame_id_bit, sid;
    logic        wq[$];
    int          miscompares = 0, check_count = 0, cycles = 0;
    cwt_regs DUT (.*);
    cwt_mcu_model mcu (.*);
    always #2 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Oldest note is taken whenever a read answer or a frame verdict appears
    always @(posedge clk) begin
        fr_d <= rx_frame_valid;
        if (rd_valid === 1'b1) chk(rd_data, rq.pop_front());
        if (fr_d) chk(wake_up_frame, wq.pop_front());
        if (++cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // Model of the bank; reserved bits drop writes
    task automatic wrx(input logic [6:0] a, input logic [15:0] d);
        mcu.wr(a, d);
        if (a == 7'h31) bt = d & 16'hfcff;
        if (a == 7'h32) hi = d;
        if (a == 7'h33) lo = d & 16'hff7f;
        sid = {hi, lo[15:8], lo[6:2]};
    endtask
    task automatic rdall();
        foreach (rq[i]) ;
        rq.push_back(bt); mcu.rd(7'h31);
        rq.push_back(hi); mcu.rd(7'h32);
        rq.push_back(lo); mcu.rd(7'h33);
        rq.push_back(16'h0); mcu.rd(7'h34);
        chk({wake_frame_id_bit, wake_frame_rtr, wake_frame_ide}, {sid, lo[1:0]});
        chk({sample_point_fraction, quanta_per_bit}, {bt[15:10], bt[7:0]});
        chk({tq_prescaler, config_valid_flag, selective_wake_active}, {tq_prescaler_in, 2'b00});
    endtask
    task automatic frame(input logic [28:0] id, input logic ide, input logic rtr, input logic exp);
        @(posedge clk) {rx_frame_valid, rx_frame_id, rx_frame_ide, rx_frame_rtr} <= {1'b1, id, ide, rtr};
        wq.push_back(exp);
        @(posedge clk) {rx_frame_valid, rx_frame_id} <= {1'b0, ~id};
    endtask
    initial begin
        void'($urandom(32'heb27));
        repeat (10) @(posedge clk);
        rst <= 0;
        {bt, hi, lo, sid} = {16'hcc96, 61'h0};
        rdall();
        repeat (8) begin
            for (int a = 7'h30; a < 7'h34; a++) wrx(7'(a), 16'($urandom));
            tq_prescaler_in <= 2'($urandom);
            rdall();
        end
        mcu.validate();
        @(negedge clk) chk(config_valid_flag, 1);
        wrx(7'h33, 16'hab7d);
        @(negedge clk) chk(config_valid_flag, 0);
        mcu.validate();
        @(posedge clk) other_config_write <= 1;
        @(posedge clk) other_config_write <= 0;
        @(negedge clk) chk(config_valid_flag, 0);
        mcu.validate();
        @(posedge clk) config_valid_clear <= 1;
        @(posedge clk) config_valid_clear <= 0;
        @(negedge clk) chk(config_valid_flag, 0);
        @(posedge clk) restart <= 1;
        @(posedge clk) restart <= 0;
        rdall();
        // Exact, id, format and type changes, then a masked-out difference
        for (int i = 0; i < 5; i++) begin
            mcu.validate();
            id_compare_mask_bit <= (i == 4) ? 29'h1ffffffe : '1;
            frame((i == 1 || i == 4) ? sid ^ 29'h1 : sid, i != 2, i == 3, i == 0 || i == 4);
        end
        frame(sid, 1'b1, 1'b0, 1'b0);
        mcu.validate();
        selective_wake_function <= 0;
        frame(sid, 1'b1, 1'b0, 1'b0);
        selective_wake_function <= 1;
        wrx(7'h33, lo & 16'hfffe);
        mcu.validate();
        frame(sid ^ 29'h3ffff, 1'b0, 1'b0, 1'b1);
        mcu.validate();
        frame(sid ^ 29'h40000, 1'b0, 1'b0, 1'b0);
        @(posedge clk) soft_reset <= 1;
        @(posedge clk) soft_reset <= 0;
        {bt, hi, lo, sid} = {16'hcc96, 61'h0};
        rdall();
        repeat (4) @(posedge clk);
        chk(rq.size() + wq.size(), 0);
        print_verdict();
    end
endmodule
bind cwt_regs cwt_regs_properties props (.*);
